// ### core/plc_ctrl_map.svh
// Functional notes
// - Remote requests only with selector in remote
// - Refuse stop-pause, run/pause-debug, debug-run/pause
// - Honour listed remote transitions
// - Link requests ignored when comms control off
// - Cold restart clears all, loads initials
// - Changed program forces cold first run
// - Reset uses configured mode; overall reset cold
// - Warm keeps retained, initialises others
// - Download or error stop forces cold
// - Invalid retained data forces cold
// - Per-class initialisation by restart mode
// - Self-diagnosis at power-on and run halts
// - Error sets summary flags, blinks stop lamp
// - Pause holds outputs at present state
// - Debug runs only as conditions permit
// - Remote reset after error resets CPU
// - Forces act only with global enable
// - Forced inputs replace input image
// - Forced outputs drive pins, image untouched
// - Force settings survive modes and resets
// - Download, backup loss, flash restart clear forces
// - Force space exceeds installed I/O
// - Stop clears output image and refreshes
// - Debug entered only from stop
// - Selector gives local run/stop; remote from stop stops, from run pauses
`ifndef PLC_CTRL_MAP_SVH
`define PLC_CTRL_MAP_SVH

// Number of force-capable points, beyond the installed I/O.
`define FORCE_POINTS 64
// Number of physically installed I/O points.
`define LOCAL_POINTS 32
// Stop lamp blink half period in milliseconds.
`define BLINK_HALF_MS 250
// Cycles per millisecond at 100 MHz.
`define CYC_PER_MS 100000
// Blink half period in cycles.
`define BLINK_CYC (`BLINK_HALF_MS * `CYC_PER_MS)
// Variable class codes as seen on the init port.
`define VCLASS_DEFAULT 2'h0
`define VCLASS_RETAIN 2'h1
`define VCLASS_INIT 2'h2
`define VCLASS_RET_INIT 2'h3

`endif

// ### core/plc_ctrl_pkg.sv
package plc_ctrl_pkg;
    // Operation modes of the CPU.
    typedef enum logic [1:0] {
        MODE_STOP = 2'h0,
        MODE_RUN = 2'h1,
        MODE_PAUSE = 2'h2,
        MODE_DEBUG = 2'h3
    } op_mode_t;
    // Mode selector positions.
    typedef enum logic [1:0] {
        SEL_STOP = 2'h0,
        SEL_RUN = 2'h1,
        SEL_REMOTE = 2'h2
    } sel_pos_t;
    // Source of a remote mode request.
    typedef enum logic [0:0] {
        SRC_TOOL = 1'h0,
        SRC_LINK = 1'h1
    } req_src_t;
    // Initialisation action for a variable.
    typedef enum logic [1:0] {
        INIT_ZERO = 2'h0,
        INIT_KEEP = 2'h1,
        INIT_USER = 2'h2
    } init_act_t;
endpackage

// ### core/plc_force_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "plc_ctrl_map.svh"

// Force store and image substitution for inputs and outputs.
module plc_force_unit #(
    parameter int N = `FORCE_POINTS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Force settings from the tool.
    input wire logic force_en,
    input wire logic set_wr,
    input wire logic set_out,
    input wire logic [$clog2(N)-1:0] set_idx,
    input wire logic set_mask,
    input wire logic set_val,
    input wire logic clear_all,
    // Refresh data.
    input wire logic [N-1:0] in_raw,
    input wire logic [N-1:0] out_image,
    output logic [N-1:0] in_forced,
    output logic [N-1:0] out_forced
);
    // Storage is kept in flip-flops indexed by point number.
    logic [N-1:0] in_mask_q;
    logic [N-1:0] in_val_q;
    logic [N-1:0] out_mask_q;
    logic [N-1:0] out_val_q;

    // Settings are accepted for any index, present module or not.
    // Only the clear event wipes them; mode and reset leave them.
    always_ff @(posedge clk) begin
        if (clear_all) begin
            in_mask_q <= '0;
            in_val_q <= '0;
            out_mask_q <= '0;
            out_val_q <= '0;
        end else if (set_wr) begin
            if (set_out) begin
                out_mask_q[set_idx] <= set_mask;
                out_val_q[set_idx] <= set_val;
            end else begin
                in_mask_q[set_idx] <= set_mask;
                in_val_q[set_idx] <= set_val;
            end
        end
    end

    // Substitution is combinational; the top registers the results.
    always_comb begin
        if (force_en) begin
            in_forced = (in_raw & ~in_mask_q) | (in_val_q & in_mask_q);
            out_forced = (out_image & ~out_mask_q) | (out_val_q & out_mask_q);
        end else begin
            in_forced = in_raw;
            out_forced = out_image;
        end
    end

    // With enable off no stored mask bit may alter either image.
    a_force_gated: assert property (@(posedge clk)
        disable iff (!nrst)
        !force_en |-> in_forced == in_raw && out_forced == out_image)
        else $error("force applied while disabled");
endmodule
`default_nettype wire

// ### core/plc_mode_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "plc_ctrl_map.svh"

// Operation mode arbiter, restart selection, diagnosis and forcing.
module plc_mode_ctrl #(
    parameter int N = `FORCE_POINTS,
    parameter int BLINK_CYC = `BLINK_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Mode selector and configuration.
    input wire plc_ctrl_pkg::sel_pos_t selector,
    input wire logic comm_ctrl_en,
    input wire logic cfg_warm,
    // Remote mode request.
    input wire logic req_valid,
    input wire plc_ctrl_pkg::req_src_t req_src,
    input wire plc_ctrl_pkg::op_mode_t req_mode,
    input wire logic req_reset,
    input wire logic req_overall,
    // Program and memory events.
    input wire logic prog_changed,
    input wire logic download,
    input wire logic backup_lost,
    input wire logic flash_restart,
    input wire logic retain_invalid,
    input wire logic debug_permit,
    // Diagnosis inputs.
    input wire logic diag_fatal,
    input wire logic diag_warn,
    // Variable initialisation query.
    input wire logic [1:0] var_class,
    // Force settings.
    input wire logic force_en,
    input wire logic set_wr,
    input wire logic set_out,
    input wire logic [$clog2(N)-1:0] set_idx,
    input wire logic set_mask,
    input wire logic set_val,
    // I/O refresh.
    input wire logic refresh,
    input wire logic [N-1:0] in_raw,
    input wire logic [N-1:0] out_image,
    output logic [N-1:0] in_image_q,
    output logic [N-1:0] out_pins_q,
    // Status.
    output plc_ctrl_pkg::op_mode_t mode_q,
    output logic req_ack_q,
    output logic req_nak_q,
    output logic cold_q,
    output plc_ctrl_pkg::init_act_t init_act_q,
    output logic init_pulse_q,
    output logic prog_exec_q,
    output logic out_clear_q,
    output logic summary_system_error_flag,
    output logic summary_system_warning_flag,
    output logic stop_lamp_q
);
    import plc_ctrl_pkg::*;

    // Internal state.
    sel_pos_t sel_prev_q;
    logic dl_err_stop_q;
    logic err_q;
    logic warn_q;
    logic [31:0] blink_cnt_q;
    logic blink_q;
    logic ok;
    logic cold_w;
    init_act_t act_w;
    logic [N-1:0] in_forced;
    logic [N-1:0] out_forced;
    op_mode_t next_mode;
    logic remote_ok;

    // True when a remote transition is allowed by the table.
    function automatic logic trans_ok(op_mode_t cur, op_mode_t nxt);
        logic r;
        r = 1'b0;
        case (cur)
            MODE_STOP: r = (nxt == MODE_RUN) || (nxt == MODE_DEBUG);
            MODE_RUN: r = (nxt == MODE_PAUSE) || (nxt == MODE_STOP);
            MODE_PAUSE: r = (nxt == MODE_RUN) || (nxt == MODE_STOP);
            MODE_DEBUG: r = (nxt == MODE_STOP);
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Remote request gate: remote position and link permission.
    always_comb begin
        remote_ok = (selector == SEL_REMOTE)
            && (req_src == SRC_TOOL || comm_ctrl_en);
        ok = req_valid && remote_ok && !err_q
            && trans_ok(mode_q, req_mode);
    end

    // Next mode from the selector, or from an accepted request.
    always_comb begin
        next_mode = mode_q;
        if (selector == SEL_RUN) begin
            next_mode = MODE_RUN;
        end else if (selector == SEL_STOP) begin
            next_mode = MODE_STOP;
        end else if (sel_prev_q == SEL_STOP) begin
            next_mode = MODE_STOP;
        end else if (sel_prev_q == SEL_RUN) begin
            next_mode = MODE_PAUSE;
        end else if (ok) begin
            next_mode = req_mode;
        end
        if (err_q) begin
            next_mode = MODE_STOP;
        end
    end

    // Mode register; reset from remote request acts like local.
    always_ff @(posedge clk) begin
        if (!nrst || (req_reset && req_valid && remote_ok)) begin
            mode_q <= MODE_STOP;
            sel_prev_q <= SEL_STOP;
        end else begin
            mode_q <= next_mode;
            sel_prev_q <= selector;
        end
    end

    // Accept and refuse reporting, one cycle pulses.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_ack_q <= 1'b0;
            req_nak_q <= 1'b0;
        end else begin
            req_ack_q <= ok || (req_valid && req_reset && remote_ok);
            req_nak_q <= req_valid && !ok
                && !(req_reset && remote_ok);
        end
    end

    // Remembers a stop caused by download or error.
    // Only an ordinary stop clears it, so cold_q stands for the whole run.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dl_err_stop_q <= 1'b0;
        end else if (download || err_q) begin
            dl_err_stop_q <= 1'b1;
        end else if (next_mode == MODE_STOP && mode_q != MODE_STOP) begin
            dl_err_stop_q <= 1'b0;
        end
    end

    plc_restart_sel u_rs (
        .cfg_warm(cfg_warm),
        .prog_changed(prog_changed),
        .stop_by_dl_err(dl_err_stop_q),
        .retain_invalid(retain_invalid),
        .overall_reset(req_overall),
        .var_class(var_class),
        .cold(cold_w),
        .act(act_w)
    );

    // Initialisation fires on entering run or debug from stop.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            init_pulse_q <= 1'b0;
            cold_q <= 1'b1;
            init_act_q <= INIT_ZERO;
        end else begin
            init_pulse_q <= (mode_q == MODE_STOP)
                && (next_mode == MODE_RUN || next_mode == MODE_DEBUG);
            cold_q <= cold_w;
            init_act_q <= act_w;
        end
    end

    // Program runs in run, in debug only when permitted.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prog_exec_q <= 1'b0;
        end else begin
            prog_exec_q <= (next_mode == MODE_RUN)
                || (next_mode == MODE_DEBUG && debug_permit);
        end
    end

    // Diagnosis: fatal latches error, warning latches warning flag.
    // Fatal checked in stop and in run; warning checked in every mode.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            err_q <= 1'b0;
            warn_q <= 1'b0;
        end else begin
            if (diag_fatal && (mode_q == MODE_RUN || mode_q == MODE_STOP))
                err_q <= 1'b1;
            else if (req_valid && req_reset && remote_ok)
                err_q <= 1'b0;
            if (diag_warn)
                warn_q <= 1'b1;
            else if (req_valid && req_reset && remote_ok)
                warn_q <= 1'b0;
        end
    end

    // Stop lamp blink divider; blink_q flips its level each half period.
    always_ff @(posedge clk) begin
        if (!nrst || !err_q) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
        end else if (blink_cnt_q == 32'(BLINK_CYC - 1)) begin
            blink_cnt_q <= '0;
            blink_q <= !blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
    end

    // Flags and lamp; lamp is steady in stop, blinks on error.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            summary_system_error_flag <= 1'b0;
            summary_system_warning_flag <= 1'b0;
            stop_lamp_q <= 1'b0;
        end else begin
            summary_system_error_flag <= err_q;
            summary_system_warning_flag <= warn_q;
            stop_lamp_q <= err_q ? blink_q : (mode_q == MODE_STOP);
        end
    end

    plc_force_unit #(.N(N)) u_force (
        .clk(clk),
        .nrst(nrst),
        .force_en(force_en),
        .set_wr(set_wr),
        .set_out(set_out),
        .set_idx(set_idx),
        .set_mask(set_mask),
        .set_val(set_val),
        .clear_all(download || backup_lost || flash_restart),
        .in_raw(in_raw),
        .out_image(out_image),
        .in_forced(in_forced),
        .out_forced(out_forced)
    );

    // Refresh: stop entry clears outputs; pause holds them.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            in_image_q <= '0;
            out_pins_q <= '0;
            out_clear_q <= 1'b0;
        end else begin
            out_clear_q <= (next_mode == MODE_STOP && mode_q != MODE_STOP);
            if (next_mode == MODE_STOP && mode_q != MODE_STOP) begin
                out_pins_q <= '0;
            end else if (refresh && mode_q != MODE_PAUSE) begin
                out_pins_q <= out_forced;
            end
            if (refresh) begin
                in_image_q <= in_forced;
            end
        end
    end

    // Named steps for the refused-request check.
    sequence s_bad_req;
        req_valid && !req_reset && selector == SEL_REMOTE
            && mode_q == MODE_DEBUG && req_mode == MODE_RUN;
    endsequence

    a_refuse_debug_run: assert property (@(posedge clk)
        disable iff (!nrst)
        s_bad_req ##0 !err_q |=> req_nak_q && mode_q == $past(mode_q))
        else $error("debug to run not refused");

    a_local_ignores_req: assert property (@(posedge clk)
        disable iff (!nrst)
        selector == SEL_STOP |=> mode_q == MODE_STOP)
        else $error("local stop not held");

    a_link_blocked: assert property (@(posedge clk)
        disable iff (!nrst)
        req_valid && req_src == SRC_LINK && !comm_ctrl_en |=> !req_ack_q)
        else $error("link request accepted while disabled");

    a_debug_from_stop: assert property (@(posedge clk)
        disable iff (!nrst)
        mode_q == MODE_DEBUG && $past(mode_q) != MODE_DEBUG
            |-> $past(mode_q) == MODE_STOP)
        else $error("debug entered from non-stop");

    // The halt shows one edge later in both mode and execution.
    a_error_halts: assert property (@(posedge clk)
        disable iff (!nrst)
        err_q |=> mode_q == MODE_STOP && !prog_exec_q)
        else $error("error did not halt program");

    a_error_flag: assert property (@(posedge clk)
        disable iff (!nrst)
        $rose(err_q) |=> summary_system_error_flag)
        else $error("error flag not set");

    a_pause_holds: assert property (@(posedge clk)
        disable iff (!nrst)
        mode_q == MODE_PAUSE && next_mode == MODE_PAUSE
            |=> $stable(out_pins_q))
        else $error("outputs moved in pause");

    a_overall_cold: assert property (@(posedge clk)
        disable iff (!nrst)
        req_overall |=> cold_q)
        else $error("overall reset not cold");

    a_stop_clears: assert property (@(posedge clk)
        disable iff (!nrst)
        mode_q != MODE_STOP && next_mode == MODE_STOP
            |=> out_pins_q == '0 && out_clear_q)
        else $error("stop entry did not clear outputs");
endmodule
`default_nettype wire

// ### core/plc_restart_sel.sv
`timescale 1ns/10ps
`default_nettype none
`include "plc_ctrl_map.svh"

// Chooses cold or warm restart and the per-class init action.
module plc_restart_sel (
    // Restart causes.
    input wire logic cfg_warm,
    input wire logic prog_changed,
    input wire logic stop_by_dl_err,
    input wire logic retain_invalid,
    input wire logic overall_reset,
    // Variable class being initialised.
    input wire logic [1:0] var_class,
    output logic cold,
    output plc_ctrl_pkg::init_act_t act
);
    import plc_ctrl_pkg::*;

    // Any override cause turns a configured warm start into cold.
    always_comb begin
        cold = !cfg_warm || prog_changed
            || stop_by_dl_err
            || retain_invalid
            || overall_reset;
    end

    // Cold: zero or user value; warm also keeps retained ones.
    always_comb begin
        case (var_class)
            `VCLASS_DEFAULT: act = INIT_ZERO;
            `VCLASS_RETAIN: act = cold ? INIT_ZERO : INIT_KEEP;
            `VCLASS_INIT: act = INIT_USER;
            `VCLASS_RET_INIT: act = cold ? INIT_USER : INIT_KEEP;
            default: act = INIT_ZERO;
        endcase
    end
endmodule
`default_nettype wire

// ### testbench/remote_party.sv
`timescale 1ns/10ps
`default_nettype none

// Programming tool or link module that sends mode and reset requests.
module remote_party (
    // Clock and the CPU's error state.
    input wire logic clk,
    input wire logic err,
    // Request lines towards the CPU.
    output logic req_valid,
    output plc_ctrl_pkg::req_src_t req_src,
    output plc_ctrl_pkg::op_mode_t req_mode,
    output logic req_reset,
    output logic req_overall
);
    import plc_ctrl_pkg::*;

    // Idle lines at time zero.
    initial begin
        req_valid = 1'b0;
        req_src = SRC_TOOL;
        req_mode = MODE_STOP;
        req_reset = 1'b0;
        req_overall = 1'b0;
    end

    // One request held over the taking edge, then released.
    task automatic send(input req_src_t s, input op_mode_t m,
                        input logic r, input logic o);
        @(posedge clk);
        req_valid <= 1'b1;
        req_src <= s;
        req_mode <= m;
        // A reset is only issued while the CPU reports an error.
        req_reset <= r && err;
        req_overall <= o && err;
        @(posedge clk);
        req_valid <= 1'b0;
        // Released source and mode show the inverse so stale values never match.
        req_src <= req_src_t'(~s);
        req_mode <= op_mode_t'(~m);
        req_reset <= 1'b0;
        req_overall <= 1'b0;
        #1;
    endtask
endmodule

`default_nettype wire

// ### testbench/tb_plc_mode_restart_force_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    mismatches++; $display("Error %s expected %0h seen %0h", nm, e, g); \
    end end

module tb_plc_mode_restart_force_ctrl;
    import plc_ctrl_pkg::*;
    localparam int N = 64;
    // Legal remote transitions, bit index is from * 4 + to.
    localparam logic [15:0] LEGAL = 16'h135A;
    logic clk = 1'b0;
    logic nrst;
    sel_pos_t selector;
    logic comm_ctrl_en, cfg_warm, prog_changed, download, backup_lost;
    logic flash_restart, retain_invalid, debug_permit, diag_fatal;
    logic diag_warn, force_en, set_wr, set_out, set_mask, set_val;
    logic refresh, req_valid, req_reset, req_overall;
    logic [1:0] var_class;
    logic [5:0] set_idx;
    logic [N-1:0] in_raw, out_image, in_image_q, out_pins_q, raw, img;
    req_src_t req_src;
    op_mode_t req_mode, mode_q;
    init_act_t init_act_q;
    logic req_ack_q, req_nak_q, cold_q, init_pulse_q, prog_exec_q;
    logic out_clear_q, summary_system_error_flag;
    logic summary_system_warning_flag, stop_lamp_q;
    // Bench model state and counters.
    int m, err_m, comparisons, mismatches;
    logic [15:0] rnd;

    // Short blink period keeps the lamp check quick.
    plc_mode_ctrl #(.N(N), .BLINK_CYC(4)) i_dut (.clk, .nrst, .selector,
        .comm_ctrl_en, .cfg_warm, .req_valid, .req_src, .req_mode,
        .req_reset, .req_overall, .prog_changed, .download, .backup_lost,
        .flash_restart, .retain_invalid, .debug_permit, .diag_fatal,
        .diag_warn, .var_class, .force_en, .set_wr, .set_out, .set_idx,
        .set_mask, .set_val, .refresh, .in_raw, .out_image, .in_image_q,
        .out_pins_q, .mode_q, .req_ack_q, .req_nak_q, .cold_q, .init_act_q,
        .init_pulse_q, .prog_exec_q, .out_clear_q, .summary_system_error_flag,
        .summary_system_warning_flag, .stop_lamp_q);

    remote_party i_remote (.clk, .err(summary_system_error_flag),
        .req_valid, .req_src, .req_mode, .req_reset, .req_overall);

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Init action expected for a variable class and restart kind.
    function automatic int exp_act(input int c, input logic cl);
        if (c == 0 || (c == 1 && cl)) return 0;
        if (c == 2 || cl) return 2;
        return 1;
    endfunction

    // Wait edges, then let the design's updates land.
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Remote mode request checked against the bench model.
    task automatic mreq(input logic s, input int t);
        int ok;
        i_remote.send(req_src_t'(s), op_mode_t'(t), 1'b0, 1'b0);
        ok = selector === SEL_REMOTE && err_m == 0 &&
             (s == 1'b0 || comm_ctrl_en) && LEGAL[m * 4 + t];
        `CHK("ack", ok, req_ack_q)
        `CHK("nak", !ok, req_nak_q)
        if (t == 1) `CHK("init", ok && m == 0, init_pulse_q)
        if (ok) m = t;
        if (err_m == 0) `CHK("mode", m, mode_q)
    endtask

    // Pulse one event: fatal, warn, download, backup loss, flash restart.
    task automatic ev(input int k);
        @(posedge clk);
        {flash_restart, backup_lost, download, diag_warn, diag_fatal}
            <= 5'(1 << k);
        @(posedge clk);
        {flash_restart, backup_lost, download, diag_warn, diag_fatal} <= '0;
        #1;
    endtask

    // Stop to run, then check restart kind and every class action.
    task automatic rs(input logic cl);
        if (m != 0) mreq(1'b0, 0);
        mreq(1'b0, 1);
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            var_class <= 2'(c);
            wt(2);
            `CHK("cold", cl, cold_q)
            `CHK("act", exp_act(c, cl), init_act_q)
        end
    endtask

    task automatic rf(input logic [N-1:0] r, input logic [N-1:0] o);
        @(posedge clk);
        in_raw <= r;
        out_image <= o;
        refresh <= 1'b1;
        @(posedge clk);
        refresh <= 1'b0;
        #1;
    endtask

    // Write one force point with its mask set.
    task automatic fs(input logic o, input int i, input logic v);
        @(posedge clk);
        {set_wr, set_out, set_mask, set_val} <= {1'b1, o, 1'b1, v};
        set_idx <= 6'(i);
        @(posedge clk);
        set_wr <= 1'b0;
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and ends the run.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test();
    end

    initial begin
        int tg;
        logic lp;
        {comm_ctrl_en, cfg_warm, prog_changed, download, backup_lost} = '0;
        {flash_restart, retain_invalid, debug_permit, diag_fatal} = '0;
        {diag_warn, force_en, set_wr, set_out, set_mask, set_val} = '0;
        {refresh, var_class, set_idx, in_raw, out_image} = '0;
        selector = SEL_STOP;
        nrst = 1'b0;
        rnd = 16'h000D;
        {m, err_m, comparisons, mismatches, tg} = '0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        wt(1);
        `CHK("reset mode", 0, mode_q)
        `CHK("reset cold", 1, cold_q)
        mreq(1'b0, 1);
        @(posedge clk);
        selector <= SEL_REMOTE;
        wt(2);
        `CHK("remote stop", 0, mode_q)
        $display("test selector finished");
        // Random targets, sources and link enable against the model.
        for (int i = 0; i < 60; i++) begin
            rnd = lfsr(rnd);
            @(posedge clk);
            comm_ctrl_en <= rnd[3];
            mreq(rnd[2], (m + 1 + rnd[5:4] % 3) % 4);
        end
        $display("test transitions finished");
        @(posedge clk);
        cfg_warm <= 1'b1;
        comm_ctrl_en <= 1'b1;
        if (m != 0) mreq(1'b0, 0);
        ev(2);
        rs(1'b1);
        rs(1'b0);
        @(posedge clk);
        prog_changed <= 1'b1;
        rs(1'b1);
        @(posedge clk);
        {prog_changed, retain_invalid} <= 2'h1;
        rs(1'b1);
        @(posedge clk);
        {retain_invalid, cfg_warm} <= 2'h0;
        rs(1'b1);
        @(posedge clk);
        cfg_warm <= 1'b1;
        $display("test restart finished");
        rnd = lfsr(rnd);
        raw = {rnd, ~rnd, rnd ^ 16'h5A5A, rnd} & ~(64'h1 << 40);
        img = {~rnd, rnd, rnd, ~rnd} | 64'h8;
        fs(1'b0, 40, 1'b1);
        fs(1'b1, 3, 1'b0);
        rf(raw, img);
        `CHK("in off", raw, in_image_q)
        `CHK("out off", img, out_pins_q)
        @(posedge clk);
        force_en <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            rf(raw, img);
            `CHK("in forced", raw | (64'h1 << 40), in_image_q)
            `CHK("out forced", img & ~64'h8, out_pins_q)
            mreq(1'b0, 0);
            mreq(1'b0, 1);
        end
        // Download, backup loss and flash restart each wipe the forces.
        for (int k = 2; k < 5; k++) begin
            mreq(1'b0, 0);
            fs(1'b0, 40, 1'b1);
            ev(k);
            mreq(1'b0, 1);
            rf(raw, img);
            `CHK("in cleared", raw, in_image_q)
        end
        $display("test force finished");
        mreq(1'b0, 2);
        rf(~raw, ~img);
        `CHK("pause hold", img, out_pins_q)
        mreq(1'b0, 0);
        `CHK("stop clear", 1, out_clear_q)
        `CHK("stop zero", 0, out_pins_q)
        mreq(1'b0, 3);
        wt(2);
        `CHK("debug hold", 0, prog_exec_q)
        @(posedge clk);
        debug_permit <= 1'b1;
        wt(2);
        `CHK("debug exec", 1, prog_exec_q)
        mreq(1'b0, 1);
        mreq(1'b0, 0);
        $display("test pause debug finished");
        mreq(1'b0, 1);
        ev(0);
        wt(1);
        `CHK("error flag", 1, summary_system_error_flag)
        `CHK("halted", 0, prog_exec_q)
        lp = stop_lamp_q;
        for (int i = 0; i < 20; i++) begin
            wt(1);
            if (stop_lamp_q !== lp) tg++;
            lp = stop_lamp_q;
        end
        `CHK("lamp blink", 1, tg >= 4)
        err_m = 1;
        mreq(1'b0, 0);
        i_remote.send(SRC_TOOL, MODE_STOP, 1'b1, 1'b1);
        wt(1);
        {err_m, m} = '0;
        `CHK("error clear", 0, summary_system_error_flag)
        `CHK("reset stop", 0, mode_q)
        rs(1'b1);
        $display("test error finished");
        mreq(1'b0, 0);
        @(posedge clk);
        selector <= SEL_RUN;
        wt(2);
        `CHK("local run", 1, mode_q)
        m = 1;
        mreq(1'b0, 0);
        ev(1);
        wt(1);
        `CHK("warn flag", 1, summary_system_warning_flag)
        $display("test local finished");
        finish_test();
    end
endmodule

`default_nettype wire
